// [src/dma_front_pkg.sv]
// constants, types and helpers for the dma front end
// assumes one clock domain for all users
package dma_front_pkg;

	localparam int NUM_CHANNELS  = 22;   // channel count
	localparam int NUM_REQUESTS  = 21;   // channels wired to a request
	localparam int NUM_TRIG_SRC  = 20;   // trigger codes 0..19
	localparam int NUM_EXT_TRIG  = 16;   // peripheral trigger codes 0..15
	localparam int NUM_OUT_TRIG  = 4;    // output trigger mux results
	localparam int CACHE_ENTRIES = 4;    // address cache entries
	localparam int CHAN_W        = 5;    // channel index width
	localparam int SEL_W         = 5;    // trigger select width
	localparam int PRIO_W        = 3;    // eight priority levels
	localparam int COUNT_W       = 10;   // words minus one, up to 1,024
	localparam int ADDR_W        = 32;   // byte address width
	localparam int CACHE_W       = 2;    // cache entry index width
	localparam int SYNC_W        = NUM_REQUESTS + NUM_EXT_TRIG;

	// request wiring: first channel of each peripheral group
	localparam int REQ_SERIAL_BASE  = 0;   // 4 ports, rx even, tx odd
	localparam int REQ_SPI_BASE     = 8;   // 2 ports, rx even, tx odd
	localparam int REQ_TWO_WIRE_BASE = 12; // 3 units, slave even
	localparam int REQ_MONITOR_BASE = 18;  // 3 monitor requests

	// trigger source codes
	localparam logic [SEL_W-1:0] TRIG_CONVERTER = 5'h00; // 0..1
	localparam logic [SEL_W-1:0] TRIG_STATE_TMR = 5'h02; // 2..3
	localparam logic [SEL_W-1:0] TRIG_TIMER     = 5'h04; // 4..11
	localparam logic [SEL_W-1:0] TRIG_PIN_INT   = 5'h0c; // 12..15
	localparam logic [SEL_W-1:0] TRIG_DMA_OUT   = 5'h10; // 16..19
	localparam logic [SEL_W-1:0] TRIG_LAST      = 5'h13; // above: none

	// address increment codes, in words per transfer
	typedef enum logic [1:0] {
		INC_NONE = 2'b00,
		INC_ONE  = 2'b01,
		INC_TWO  = 2'b10,
		INC_FOUR = 2'b11
	} inc_t;

	localparam int SHIFT_ONE  = 2;   // one word is four bytes
	localparam int SHIFT_TWO  = 3;
	localparam int SHIFT_FOUR = 4;

	// channel state
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_RUN   = 2'b10
	} chan_state_t;

	// per channel configuration as loaded by the config port
	typedef struct packed {
		logic [ADDR_W-1:0]  src_base;
		logic [ADDR_W-1:0]  dst_base;
		logic [COUNT_W-1:0] count;
		inc_t               src_inc;
		inc_t               dst_inc;
		logic [PRIO_W-1:0]  prio;
		logic [SEL_W-1:0]   sel;
		logic               use_trig;
		logic               use_req;
	} chan_cfg_t;

	// byte offset of word number idx for an increment setting
	function automatic logic [ADDR_W-1:0] addr_offset(
		input logic [COUNT_W-1:0] idx,
		input inc_t               inc);
		logic [ADDR_W-1:0] wide;
		wide = ADDR_W'(idx);
		case (inc)
			INC_ONE:  addr_offset = wide << SHIFT_ONE;
			INC_TWO:  addr_offset = wide << SHIFT_TWO;
			INC_FOUR: addr_offset = wide << SHIFT_FOUR;
			default:  addr_offset = '0;
		endcase
	endfunction

endpackage

// [src/arb_if.sv]
// bundle between channel core and arbiter
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
`default_nettype none
interface arb_if;
	import dma_front_pkg::*;
	logic [NUM_CHANNELS-1:0] ready;               // channel wants a beat
	logic [PRIO_W-1:0]       prio [NUM_CHANNELS]; // 0 is highest
	logic                    grant_valid;         // some channel won
	logic [CHAN_W-1:0]       grant_index;         // the winner

	modport core (output ready, prio, input grant_valid, grant_index);
	modport arbiter (input ready, prio, output grant_valid, grant_index);
endinterface
`default_nettype wire

// [src/sync_stage.sv]
// two flop synchroniser for independent levels
// assumes each bit is a level or long pulse
`timescale 1ns/100ps
`default_nettype none
module sync_stage #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;   // first stage, read by second only

	// two stages, reset to idle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// [src/prio_arbiter.sv]
// picks one ready channel each cycle by priority level
// assumes ready and priority are stable within the cycle
`timescale 1ns/100ps
`default_nettype none
module prio_arbiter
	import dma_front_pkg::*;
(
	arb_if.arbiter arb
);
	logic              found;   // a ready channel seen
	logic [PRIO_W-1:0] best;    // best level so far
	logic [CHAN_W-1:0] winner;  // best channel so far

	// scan downward so equal levels favour the lowest channel
	always_comb begin
		found  = 1'b0;
		best   = '0;
		winner = '0;
		for (int c = NUM_CHANNELS - 1; c >= 0; c--) begin
			if (arb.ready[c] && (!found || arb.prio[c] <= best)) begin
				found  = 1'b1;
				best   = arb.prio[c];
				winner = CHAN_W'(c);
			end
		end
	end

	// result goes straight back to the core
	assign arb.grant_valid = found;
	assign arb.grant_index = winner;
endmodule
`default_nettype wire

// [src/dma_front_end.sv]
// request/trigger front end of a 22 channel dma controller
// assumes peripherals hold requests as levels and the bus takes one
// beat per cycle while bus_ready is high
//
// Operation
// - 22 channels, last one has no request
// - per channel selector picks one of 20 triggers
// - fixed trigger code map
// - trigger independent of the request input
// - every channel drives a trigger output
// - output mux results are codes 16..19
// - completion of one channel can start another
// - channels 0..11 serve serial and spi ports
// - channels 12..20 serve two wire units, monitors
// - per channel priority with eight levels
// - arbitration re-evaluated every cycle
// - four entry cache of address pairs
// - one transfer moves up to 1,024 words
// - separate source and destination increments
// - one combined interrupt output
// - runs in sleep
// - triggered transfer still paced by request
`timescale 1ns/100ps
`default_nettype none
module dma_front_end
	import dma_front_pkg::*;
(
	input  wire logic                    clock,
	input  wire logic                    reset_n,
	input  wire logic [3:0]              serial_rx_request,
	input  wire logic [3:0]              serial_tx_request,
	input  wire logic [1:0]              spi_rx_request,
	input  wire logic [1:0]              spi_tx_request,
	input  wire logic [2:0]              two_wire_slave_request,
	input  wire logic [2:0]              two_wire_master_request,
	input  wire logic [2:0]              two_wire_monitor_request,
	input  wire logic [1:0]              converter_seq_trigger,
	input  wire logic [1:0]              state_timer_trigger,
	input  wire logic [7:0]              timer_match_trigger,
	input  wire logic [3:0]              pin_interrupt_trigger,
	input  wire logic                    cfg_write,
	input  wire logic [CHAN_W-1:0]       cfg_channel,
	input  wire logic [ADDR_W-1:0]       cfg_src_base,
	input  wire logic [ADDR_W-1:0]       cfg_dst_base,
	input  wire logic [COUNT_W-1:0]      cfg_count,
	input  wire logic [1:0]              cfg_src_inc,
	input  wire logic [1:0]              cfg_dst_inc,
	input  wire logic [PRIO_W-1:0]       cfg_priority,
	input  wire logic [SEL_W-1:0]        cfg_trigger_select,
	input  wire logic                    cfg_use_trigger,
	input  wire logic                    cfg_use_request,
	input  wire logic                    otm_write,
	input  wire logic [1:0]              otm_index,
	input  wire logic [CHAN_W-1:0]       otm_channel,
	input  wire logic                    bus_ready,
	output logic                         beat_valid,
	output logic      [CHAN_W-1:0]       beat_channel,
	output logic      [ADDR_W-1:0]       beat_src_addr,
	output logic      [ADDR_W-1:0]       beat_dst_addr,
	output logic      [NUM_CHANNELS-1:0] channel_busy,
	output logic      [NUM_CHANNELS-1:0] channel_trigger_out,
	output logic                         dma_interrupt
);

	// raw and synchronised inputs
	logic [NUM_REQUESTS-1:0] req_raw;     // request lines by channel
	logic [NUM_EXT_TRIG-1:0] ext_raw;     // peripheral triggers 0..15
	logic [SYNC_W-1:0]       sync_vec;    // after two flops
	logic [NUM_CHANNELS-1:0] chan_req;    // request per channel
	logic [NUM_TRIG_SRC-1:0] trig_src;    // trigger codes 0..19
	logic [NUM_OUT_TRIG-1:0] otm_out;     // output mux results

	// per channel state
	chan_cfg_t               cfg_q   [NUM_CHANNELS];
	chan_state_t             state_q [NUM_CHANNELS];
	logic [COUNT_W-1:0]      done_q  [NUM_CHANNELS];  // words issued
	logic [NUM_CHANNELS-1:0] trig_lvl_q;  // last trigger level
	logic [CHAN_W-1:0]       otm_sel_q [NUM_OUT_TRIG]; // mux sources

	// per channel decode
	logic [NUM_CHANNELS-1:0] trig_level;  // selected trigger
	logic [NUM_CHANNELS-1:0] trig_edge;   // rising edge of it
	logic [NUM_CHANNELS-1:0] cfg_hit;     // config write here
	logic [NUM_CHANNELS-1:0] mine;        // beat issued here
	logic [NUM_CHANNELS-1:0] finish;      // last beat issued here

	// address cache
	logic                    cache_valid_q [CACHE_ENTRIES];
	logic [CHAN_W-1:0]       cache_tag_q   [CACHE_ENTRIES];
	logic [ADDR_W-1:0]       cache_src_q   [CACHE_ENTRIES];
	logic [ADDR_W-1:0]       cache_dst_q   [CACHE_ENTRIES];
	logic [CACHE_W-1:0]      repl_q;      // next victim entry
	logic                    hit;         // granted channel cached
	logic [CACHE_W-1:0]      hit_idx;     // entry that hit
	logic [CACHE_W-1:0]      fill_idx;    // entry to write

	// granted beat
	arb_if                   arb ();
	logic                    take;        // beat issued this cycle
	chan_cfg_t               g_cfg;       // winner configuration
	logic [COUNT_W-1:0]      g_done;      // winner words issued
	logic                    g_last;      // winner on last word
	logic [ADDR_W-1:0]       cur_src;     // address of this beat
	logic [ADDR_W-1:0]       cur_dst;
	logic [ADDR_W-1:0]       next_src;    // address of next beat
	logic [ADDR_W-1:0]       next_dst;

	// fixed request wiring, channel 21 has none
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_serial
			assign req_raw[REQ_SERIAL_BASE + 2*i]     =
				serial_rx_request[i];
			assign req_raw[REQ_SERIAL_BASE + 2*i + 1] =
				serial_tx_request[i];
		end
		for (i = 0; i < 2; i++) begin : g_spi
			assign req_raw[REQ_SPI_BASE + 2*i]     =
				spi_rx_request[i];
			assign req_raw[REQ_SPI_BASE + 2*i + 1] =
				spi_tx_request[i];
		end
		for (i = 0; i < 3; i++) begin : g_two_wire
			assign req_raw[REQ_TWO_WIRE_BASE + 2*i]     =
				two_wire_slave_request[i];
			assign req_raw[REQ_TWO_WIRE_BASE + 2*i + 1] =
				two_wire_master_request[i];
			assign req_raw[REQ_MONITOR_BASE + i] =
				two_wire_monitor_request[i];
		end
	endgenerate

	// peripheral triggers in code order 0..15
	assign ext_raw = {pin_interrupt_trigger, timer_match_trigger,
		state_timer_trigger, converter_seq_trigger};

	// outside levels cross two flops
	sync_stage #(
		.WIDTH    (SYNC_W)
	) u_sync (
		.clock    (clock),
		.reset_n  (reset_n),
		.async_in ({ext_raw, req_raw}),
		.sync_out (sync_vec)
	);

	// spare channel has no request
	assign chan_req = {1'b0, sync_vec[NUM_REQUESTS-1:0]};

	// output trigger mux feeds codes 16..19
	generate
		for (i = 0; i < NUM_OUT_TRIG; i++) begin : g_otm
			assign otm_out[i] = (otm_sel_q[i] < CHAN_W'(NUM_CHANNELS))
				& channel_trigger_out[otm_sel_q[i]];
		end
	endgenerate
	assign trig_src = {otm_out, sync_vec[SYNC_W-1:NUM_REQUESTS]};

	// output mux selectors, reset to no source
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int k = 0; k < NUM_OUT_TRIG; k++) begin
				otm_sel_q[k] <= '1;
			end
		end else if (otm_write) begin
			otm_sel_q[otm_index] <= otm_channel;
		end
	end

	// per channel decode and hand-off to the arbiter
	generate
		for (i = 0; i < NUM_CHANNELS; i++) begin : g_chan
			// codes above the last select nothing
			assign trig_level[i] = (cfg_q[i].sel <= TRIG_LAST)
				& trig_src[cfg_q[i].sel];
			assign trig_edge[i] = trig_level[i] & ~trig_lvl_q[i];
			assign cfg_hit[i] = cfg_write
				&& cfg_channel == CHAN_W'(i);
			assign mine[i] = take && arb.grant_index == CHAN_W'(i);
			assign finish[i] = mine[i]
				&& done_q[i] == cfg_q[i].count;
			// request pacing holds even after a trigger start
			assign arb.ready[i] = state_q[i] == ST_RUN
				&& (!cfg_q[i].use_req || chan_req[i]);
			assign arb.prio[i] = cfg_q[i].prio;
		end
	endgenerate

	// channel state machines; clock never gated
	generate
		for (i = 0; i < NUM_CHANNELS; i++) begin : g_fsm
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					cfg_q[i]      <= '0;
					state_q[i]    <= ST_IDLE;
					done_q[i]     <= '0;
					trig_lvl_q[i] <= 1'b0;
				end else begin
					trig_lvl_q[i] <= trig_level[i];
					if (cfg_hit[i]) begin
						// loading a channel arms it afresh
						cfg_q[i] <= '{cfg_src_base, cfg_dst_base,
							cfg_count, inc_t'(cfg_src_inc),
							inc_t'(cfg_dst_inc), cfg_priority,
							cfg_trigger_select, cfg_use_trigger,
							cfg_use_request};
						state_q[i] <= ST_ARMED;
						done_q[i]  <= '0;
					end else begin
						case (state_q[i])
							ST_ARMED: begin
								// start at once or on trigger edge
								if (!cfg_q[i].use_trig || trig_edge[i]) begin
									state_q[i] <= ST_RUN;
								end
							end
							ST_RUN: begin
								if (mine[i]) begin
									done_q[i] <= done_q[i] + 1'b1;
								end
								if (finish[i]) begin
									state_q[i] <= ST_IDLE;
								end
							end
							default: begin
								state_q[i] <= ST_IDLE;
							end
						endcase
					end
				end
			end
		end
	endgenerate

	// priority pick, redone every cycle
	prio_arbiter u_arbiter (
		.arb (arb.arbiter)
	);

	// beat leaves when holding register frees
	assign take = arb.grant_valid && (!beat_valid || bus_ready);

	// winner's configuration and progress
	assign g_cfg  = cfg_q[arb.grant_index];
	assign g_done = done_q[arb.grant_index];
	assign g_last = g_done == g_cfg.count;

	// cache lookup for the winner
	always_comb begin
		hit     = 1'b0;
		hit_idx = '0;
		for (int e = 0; e < CACHE_ENTRIES; e++) begin
			if (cache_valid_q[e] && cache_tag_q[e] == arb.grant_index) begin
				hit     = 1'b1;
				hit_idx = CACHE_W'(e);
			end
		end
	end
	assign fill_idx = hit ? hit_idx : repl_q;

	// beat address: cached, else base plus offset
	assign cur_src = hit ? cache_src_q[hit_idx]
		: g_cfg.src_base + addr_offset(g_done, g_cfg.src_inc);
	assign cur_dst = hit ? cache_dst_q[hit_idx]
		: g_cfg.dst_base + addr_offset(g_done, g_cfg.dst_inc);
	assign next_src = cur_src + addr_offset(COUNT_W'(1), g_cfg.src_inc);
	assign next_dst = cur_dst + addr_offset(COUNT_W'(1), g_cfg.dst_inc);

	// cache update; reload drops entry
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			repl_q <= '0;
			for (int e = 0; e < CACHE_ENTRIES; e++) begin
				cache_valid_q[e] <= 1'b0;
				cache_tag_q[e]   <= '0;
				cache_src_q[e]   <= '0;
				cache_dst_q[e]   <= '0;
			end
		end else begin
			if (take && !hit) begin
				repl_q <= repl_q + 1'b1;              // round robin victim
			end
			for (int e = 0; e < CACHE_ENTRIES; e++) begin
				if (take && fill_idx == CACHE_W'(e)) begin
					// keep the pair for the next beat
					cache_valid_q[e] <= !g_last;
					cache_tag_q[e]   <= arb.grant_index;
					cache_src_q[e]   <= next_src;
					cache_dst_q[e]   <= next_dst;
				end
				// stale pair after reload
				if (cfg_write && (take && fill_idx == CACHE_W'(e)
					? arb.grant_index : cache_tag_q[e]) == cfg_channel) begin
					cache_valid_q[e] <= 1'b0;
				end
			end
		end
	end

	// beat holding register toward the bus
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			beat_valid    <= 1'b0;
			beat_channel  <= '0;
			beat_src_addr <= '0;
			beat_dst_addr <= '0;
		end else if (take) begin
			beat_valid    <= 1'b1;
			beat_channel  <= arb.grant_index;
			beat_src_addr <= cur_src;
			beat_dst_addr <= cur_dst;
		end else if (bus_ready) begin
			beat_valid    <= 1'b0;                  // accepted, none next
		end
	end

	// completions, busy flags, interrupt
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			channel_trigger_out <= '0;
			channel_busy        <= '0;
			dma_interrupt       <= 1'b0;
		end else begin
			channel_trigger_out <= finish;
			dma_interrupt       <= |finish;
			for (int c = 0; c < NUM_CHANNELS; c++) begin
				channel_busy[c] <= state_q[c] != ST_IDLE;
			end
		end
	end

endmodule
`default_nettype wire

// [testbench/dma_front_end_props.sv]
// port checks on the dma front end
// assumes one clock domain and an active low asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module dma_front_end_props
	import dma_front_pkg::*;
(
	input wire logic                    clock,
	input wire logic                    reset_n,
	input wire logic                    cfg_write,
	input wire logic [CHAN_W-1:0]       cfg_channel,
	input wire logic                    bus_ready,
	input wire logic                    beat_valid,
	input wire logic [CHAN_W-1:0]       beat_channel,
	input wire logic [ADDR_W-1:0]       beat_src_addr,
	input wire logic [ADDR_W-1:0]       beat_dst_addr,
	input wire logic [NUM_CHANNELS-1:0] channel_busy,
	input wire logic [NUM_CHANNELS-1:0] channel_trigger_out,
	input wire logic                    dma_interrupt
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// stall holds the beat
	property p_beat_hold;
		beat_valid && !bus_ready |=> beat_valid && $stable(beat_channel)
			&& $stable(beat_src_addr) && $stable(beat_dst_addr);
	endproperty
	a_beat_hold: assert property (p_beat_hold)
		else $error("beat moved in stall");

	// interrupt is or of completions
	property p_irq_or;
		dma_interrupt == (|channel_trigger_out);
	endproperty
	a_irq_or: assert property (p_irq_or)
		else $error("bad interrupt");

	// completions last one cycle
	property p_trig_pulse;
		(|channel_trigger_out) |=>
			(channel_trigger_out & $past(channel_trigger_out)) == '0;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse)
		else $error("long trigger");

	// last beat is held while its completion shows
	property p_trig_src;
		(|channel_trigger_out) |-> beat_valid;
	endproperty
	a_trig_src: assert property (p_trig_src)
		else $error("trigger without beat");

	// at most one completion a cycle
	property p_one_done;
		$onehot0(channel_trigger_out);
	endproperty
	a_one_done: assert property (p_one_done)
		else $error("two completions");

	// beats only name real channels
	property p_chan_range;
		beat_valid |-> beat_channel < CHAN_W'(NUM_CHANNELS);
	endproperty
	a_chan_range: assert property (p_chan_range)
		else $error("bad beat channel");

	// quiet at first edge after reset
	property p_reset_quiet;
		$rose(reset_n) |-> !beat_valid && channel_busy == '0
			&& !dma_interrupt;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("active after reset");

	// configured channel busy two edges on
	property p_cfg_busy;
		cfg_write && cfg_channel < CHAN_W'(NUM_CHANNELS) |->
			##2 channel_busy[$past(cfg_channel, 2)];
	endproperty
	a_cfg_busy: assert property (p_cfg_busy)
		else $error("not busy after config");

	// main scenarios reached
	c_stall: cover property (beat_valid && !bus_ready);
	c_irq: cover property (dma_interrupt);
	c_spare: cover property (beat_valid && beat_channel == 5'h15);
endmodule

bind dma_front_end dma_front_end_props dma_front_end_props_i (
	.clock, .reset_n, .cfg_write, .cfg_channel, .bus_ready, .beat_valid,
	.beat_channel, .beat_src_addr, .beat_dst_addr, .channel_busy,
	.channel_trigger_out, .dma_interrupt
);
`default_nettype wire

// [testbench/bus_periph_model.sv]
// far side: bus taking beats, peripherals requesting
// assumes beats are accepted at rising edges with bus_ready high
`timescale 1ns/100ps
`default_nettype none
module bus_periph_model
	import dma_front_pkg::*;
(
	input  wire logic                    clock,
	input  wire logic                    reset_n,
	input  wire logic                    hold,
	input  wire logic                    slow,
	input  wire logic [NUM_REQUESTS-1:0] want,
	input  wire logic                    beat_valid,
	input  wire logic [CHAN_W-1:0]       beat_channel,
	output logic                         bus_ready,
	output logic      [NUM_REQUESTS-1:0] request
);
	logic                    phase_q; // alternating acceptance slot
	logic [NUM_REQUESTS-1:0] taken;   // channel whose word moved

	assign taken = (beat_valid && bus_ready) ?
		NUM_REQUESTS'(1) << beat_channel : '0;
	// stall on hold, every other cycle when slow
	assign bus_ready = !hold && (!slow || phase_q);

	// acceptance slot toggles each cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= !phase_q;
		end
	end

	// request while a peripheral word waits
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			request <= '0;
		end else begin
			request <= (request | want) & ~taken;
		end
	end
endmodule
`default_nettype wire

// [testbench/dma_front_end_tb.sv]
// self-checking bench for the dma front end
// assumes the bus model on the far side
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) begin \
			num_errors++; \
			$display("BAD %s exp %0h got %0h", what, exp, got); \
		end \
	end
module dma_front_end_tb;
	import dma_front_pkg::*;
	logic                    clock = 1'b0;
	logic                    reset_n = 1'b0;
	logic [15:0]             trig = '0;  // trigger codes 0..15
	logic                    cfg_write = 1'b0;
	logic [CHAN_W-1:0]       cfg_channel;
	logic [ADDR_W-1:0]       cfg_src_base;
	logic [ADDR_W-1:0]       cfg_dst_base;
	logic [COUNT_W-1:0]      cfg_count;
	logic [1:0]              cfg_src_inc;
	logic [1:0]              cfg_dst_inc;
	logic [PRIO_W-1:0]       cfg_priority;
	logic [SEL_W-1:0]        cfg_trigger_select;
	logic                    cfg_use_trigger;
	logic                    cfg_use_request;
	logic                    otm_write = 1'b0;
	logic [1:0]              otm_index;
	logic [CHAN_W-1:0]       otm_channel;
	logic                    hold = 1'b0;  // stall the bus
	logic                    slow = 1'b0;  // bus every other cycle
	logic [NUM_REQUESTS-1:0] want = '0;    // peripheral gets a word
	logic [NUM_REQUESTS-1:0] request;
	logic                    bus_ready, beat_valid, dma_interrupt;
	logic [CHAN_W-1:0]       beat_channel;
	logic [ADDR_W-1:0]       beat_src_addr, beat_dst_addr;
	logic [CHAN_W-1:0]       got_ch [$];   // accepted beats
	logic [ADDR_W-1:0]       got_src [$], got_dst [$];
	int                      irq_n, n_tests, num_errors;

	dma_front_end dma_front_end_i (
		.clock, .reset_n,
		// fixed wiring: rx and slave even, tx and master odd
		.serial_rx_request({request[6], request[4], request[2], request[0]}),
		.serial_tx_request({request[7], request[5], request[3], request[1]}),
		.spi_rx_request({request[10], request[8]}),
		.spi_tx_request({request[11], request[9]}),
		.two_wire_slave_request({request[16], request[14], request[12]}),
		.two_wire_master_request({request[17], request[15], request[13]}),
		.two_wire_monitor_request(request[20:18]),
		.converter_seq_trigger(trig[1:0]), .state_timer_trigger(trig[3:2]),
		.timer_match_trigger(trig[11:4]), .pin_interrupt_trigger(trig[15:12]),
		.cfg_write, .cfg_channel, .cfg_src_base, .cfg_dst_base, .cfg_count,
		.cfg_src_inc, .cfg_dst_inc, .cfg_priority, .cfg_trigger_select,
		.cfg_use_trigger, .cfg_use_request, .otm_write, .otm_index,
		.otm_channel, .bus_ready, .beat_valid, .beat_channel, .beat_src_addr,
		.beat_dst_addr, .channel_busy(), .channel_trigger_out(),
		.dma_interrupt
	);

	bus_periph_model bus_periph_model_i (
		.clock, .reset_n, .hold, .slow, .want, .beat_valid, .beat_channel,
		.bus_ready, .request
	);

	// clock at 25 MHz
	initial begin
		forever #20 clock = ~clock;
	end

	// record accepted beats and interrupts
	always @(posedge clock) begin
		if (beat_valid === 1'b1 && bus_ready === 1'b1) begin
			got_ch.push_back(beat_channel);
			got_src.push_back(beat_src_addr);
			got_dst.push_back(beat_dst_addr);
		end
		if (dma_interrupt === 1'b1) begin
			irq_n++;
		end
	end

	// bytes per beat for an increment code
	function automatic int incb(input int c);
		return (c == 0) ? 0 : 2 << c;
	endfunction

	task automatic clear;
		got_ch.delete();
		got_src.delete();
		got_dst.delete();
		irq_n = 0;
	endtask

	// load one channel; bases from channel number
	task automatic cfg(input int ch, cnt, si, di, pr, sel, ut, ur);
		cfg_write          <= 1'b1;
		cfg_channel        <= CHAN_W'(ch);
		cfg_src_base       <= ADDR_W'(ch) << 12;
		cfg_dst_base       <= (ADDR_W'(ch) << 12) + 32'h0001_0000;
		cfg_count          <= COUNT_W'(cnt);
		cfg_src_inc        <= 2'(si);
		cfg_dst_inc        <= 2'(di);
		cfg_priority       <= PRIO_W'(pr);
		cfg_trigger_select <= SEL_W'(sel);
		cfg_use_trigger    <= ut[0];
		cfg_use_request    <= ur[0];
		@(posedge clock);
		cfg_write <= 1'b0;
		@(posedge clock);
	endtask

	task automatic otm(input int idx, ch);
		otm_write   <= 1'b1;
		otm_index   <= 2'(idx);
		otm_channel <= CHAN_W'(ch);
		@(posedge clock);
		otm_write <= 1'b0;
		@(posedge clock);
	endtask

	// wait for n beats, then check none follow
	task automatic wait_beats(input int n);
		int i;
		i = 0;
		while (got_ch.size() < n && i < 3000) begin
			@(posedge clock);
			i++;
		end
		repeat (8) @(posedge clock);
		`CHECK("beat count", n, got_ch.size())
	endtask

	// beat i is word n of channel ch
	task automatic check_beat(input int i, ch, n, si, di);
		logic [ADDR_W-1:0] sb;
		sb = ADDR_W'(ch) << 12;
		`CHECK("channel", CHAN_W'(ch), got_ch[i])
		`CHECK("src", sb + ADDR_W'(n * incb(si)), got_src[i])
		`CHECK("dst", sb + 32'h0001_0000 + ADDR_W'(n * incb(di)), got_dst[i])
	endtask

	// spare channel copy, two strides, full count
	task automatic t_copy;
		int si [2] = '{1, 3};
		int di [2] = '{2, 0};
		int cn [2] = '{3, 1023};
		for (int k = 0; k < 2; k++) begin
			clear();
			slow <= (k == 0);
			cfg(21, cn[k], si[k], di[k], 0, 31, 0, 0);
			wait_beats(cn[k] + 1);
			check_beat(0, 21, 0, si[k], di[k]);
			check_beat(cn[k], 21, cn[k], si[k], di[k]);
			`CHECK("interrupts", 1, irq_n)
		end
		slow <= 1'b0;
	endtask

	// each request paces its own channel
	task automatic t_wire;
		for (int ch = 0; ch < NUM_REQUESTS; ch++) begin
			clear();
			cfg(ch, 0, 1, 1, 0, 31, 0, 1);
			repeat (6) @(posedge clock);
			`CHECK("early beats", 0, got_ch.size())
			want <= NUM_REQUESTS'(1) << ch;
			@(posedge clock);
			want <= '0;
			wait_beats(1);
			check_beat(0, ch, 0, 1, 1);
		end
	endtask

	// only the selected code starts an armed channel
	task automatic t_trig;
		for (int c = 0; c <= NUM_TRIG_SRC; c++) begin
			clear();
			cfg(5, 0, 1, 1, 0, c, 1, 0);
			trig <= (c < 16) ? ~(16'h0001 << c) : 16'hffff;
			repeat (4) @(posedge clock);
			trig <= '0;
			repeat (6) @(posedge clock);
			`CHECK("stray start", 0, got_ch.size())
			if (c < 16) begin
				trig <= 16'h0001 << c;
				repeat (4) @(posedge clock);
				trig <= '0;
				wait_beats(1);
				check_beat(0, 5, 0, 1, 1);
			end
		end
	endtask

	// spare channel chains to channel 1 via each mux output
	task automatic t_chain;
		for (int k = 0; k < NUM_OUT_TRIG; k++) begin
			clear();
			for (int j = 0; j < NUM_OUT_TRIG; j++) begin
				otm(j, (j == k) ? 21 : 31);
			end
			cfg(1, 0, 1, 1, 0, 16 + k, 1, 1);
			cfg(21, 0, 1, 1, 0, 31, 0, 0);
			wait_beats(1);
			`CHECK("first channel", CHAN_W'(21), got_ch[0])
			want <= 21'h000002;
			@(posedge clock);
			want <= '0;
			wait_beats(2);
			check_beat(1, 1, 0, 1, 1);
		end
	endtask

	// urgent channel overtakes a stalled running one
	task automatic t_prio;
		int ex [8] = '{10, 11, 11, 11, 11, 10, 10, 10};
		int nx [8] = '{0, 0, 1, 2, 3, 1, 2, 3};
		clear();
		hold <= 1'b1;
		cfg(10, 3, 1, 1, 7, 31, 0, 0);
		cfg(11, 3, 1, 1, 0, 31, 0, 0);
		repeat (4) @(posedge clock);
		hold <= 1'b0;
		wait_beats(8);
		for (int i = 0; i < 8; i++) begin
			check_beat(i, ex[i], nx[i], 1, 1);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		t_copy();
		t_wire();
		t_trig();
		t_chain();
		t_prio();
		stop_test();
	end

	// watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
